// ### rtl/cellx_pkg.sv
// Summary of operation
// - enable asserted: next cycle first byte plus marker
// - start marker driven on link rising edge
// - five-bit slave select pins are inputs
// - strap low ties off enable and marker
// - strap one selects address function on shared pins
// - select bit zero tied off when disabled
// - available high once a whole cell, capped at 16 bytes, is queued, and while a cell is being sent
// - cell bytes change on link rising edges
package cellx_pkg;
    localparam int          DATA_W      = 8;
    localparam int          ADDR_W      = 5;
    localparam int          CELL_BYTES  = 53;
    localparam int          FIFO_DEPTH  = 8;
    localparam logic [4:0]  SLAVE_ADDR  = 5'h00;
    localparam logic [7:0]  BUS_RESET   = 8'h00;

    typedef struct packed {
        logic       first;
        logic [7:0] data;
    } cellx_word_t;
endpackage : cellx_pkg

// ### rtl/cellx_fifo.sv
`timescale 1ns/10ps
module cellx_fifo #(
    parameter int W = 9,
    parameter int D = 8
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_r [D];
    logic [AW:0]  wr_r;
    logic [AW:0]  rd_r;
    logic         push;
    logic         pop;

    assign in_ready  = (wr_r - rd_r) != (AW+1)'(D);
    assign out_valid = wr_r != rd_r;
    assign out_data  = mem_r[rd_r[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wr_r[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_r <= '0;
            rd_r <= '0;
        end else begin
            if (push) begin
                wr_r <= wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= rd_r + 1'b1;
            end
        end
    end
endmodule : cellx_fifo

// ### rtl/cellx_tx_port.sv
`timescale 1ns/10ps
// core side: bytes enter a FIFO on core_clk; the link side drains it through
// a gray-pointer async queue written on core_clk and read on cell_tx_clock.
module cellx_tx_port #(
    parameter int          CELL_BYTES = cellx_pkg::CELL_BYTES,
    parameter logic [4:0]  MY_ADDR    = cellx_pkg::SLAVE_ADDR
) (
    // core clock and reset
    input  wire logic         core_clk,
    input  wire logic         reset,
    // core byte stream
    input  wire logic         src_valid,
    output logic              src_ready,
    input  wire logic [7:0]   src_data,
    // strap
    input  wire logic         cell_port_select_strap,
    // link
    input  wire logic         cell_tx_clock,
    input  wire logic         cell_tx_enable_n,
    input  wire logic [4:1]   cell_tx_slave_select,
    input  wire logic         cell_tx_select_bit_zero,
    output logic [7:0]        cell_tx_bus,
    output logic              cell_tx_bus_oe,
    output logic              cell_tx_start_marker,
    output logic              cell_tx_start_marker_oe,
    output logic              cell_tx_available,
    output logic              cell_tx_available_oe
);
    localparam int AQ = 16; // async queue depth, two cells' headroom not needed
    localparam int CW = $clog2(CELL_BYTES + 1);

    // strap is a pin: two flops before anything reads it
    logic        strap_s1;
    logic        strap_r;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            strap_s1 <= 1'b0;
            strap_r  <= 1'b0;
        end else begin
            strap_s1 <= cell_port_select_strap;
            strap_r  <= strap_s1;
        end
    end

    // mark first byte of each cell on the core side
    logic [CW-1:0] in_cnt_r;
    cellx_pkg::cellx_word_t f_in, f_out;
    logic f_ready, f_valid, f_pop;
    assign f_in.first = (in_cnt_r == '0);
    assign f_in.data  = src_data;
    assign src_ready  = f_ready && strap_r;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            in_cnt_r <= '0;
        end else if (src_valid && src_ready) begin
            in_cnt_r <= (in_cnt_r == CW'(CELL_BYTES - 1)) ? '0 : in_cnt_r + 1'b1;
        end
    end

    cellx_fifo #(.W(9), .D(cellx_pkg::FIFO_DEPTH)) u_fifo (
        .clk       (core_clk),
        .rst       (reset),
        .in_valid  (src_valid && strap_r),
        .in_ready  (f_ready),
        .in_data   (f_in),
        .out_valid (f_valid),
        .out_ready (f_pop),
        .out_data  (f_out)
    );

    // async queue storage written on core clock, gray pointers
    logic [8:0] aq_r [AQ];
    logic [4:0] wbin_r, wgray_r, rgray_s1, rgray_s2;
    logic [4:0] rbin_r, rgray_r, wgray_l1, wgray_l2;
    logic [4:0] rbin_c;
    always_comb begin
        rbin_c = '0;
        for (int i = 4; i >= 0; i--) begin
            rbin_c[i] = (i == 4) ? rgray_s2[4] : rbin_c[i+1] ^ rgray_s2[i];
        end
    end
    assign f_pop = f_valid && ((wbin_r - rbin_c) != 5'd16);

    always_ff @(posedge core_clk) begin
        if (f_pop) begin
            aq_r[wbin_r[3:0]] <= f_out;
        end
    end
    always_ff @(posedge core_clk) begin
        if (reset) begin
            wbin_r   <= '0;
            wgray_r  <= '0;
            rgray_s1 <= '0;
            rgray_s2 <= '0;
        end else begin
            rgray_s1 <= rgray_r;
            rgray_s2 <= rgray_s1;
            if (f_pop) begin
                wbin_r  <= wbin_r + 1'b1;
                wgray_r <= (wbin_r + 1'b1) ^ ((wbin_r + 1'b1) >> 1);
            end
        end
    end

    // link domain: reset and strap synchronised
    logic lrst_s1, lrst_s2, lstrap_s1, lstrap_s2;
    always_ff @(posedge cell_tx_clock) begin
        lrst_s1   <= reset;
        lrst_s2   <= lrst_s1;
        lstrap_s1 <= strap_r;
        lstrap_s2 <= lstrap_s1;
    end

    // count bytes queued on link side
    logic [4:0] wbin_l;
    always_comb begin
        wbin_l = '0;
        for (int i = 4; i >= 0; i--) begin
            wbin_l[i] = (i == 4) ? wgray_l2[4] : wbin_l[i+1] ^ wgray_l2[i];
        end
    end
    logic [4:0] fill_l;
    assign fill_l = wbin_l - rbin_r;

    // addressing: strap one gives address function tied off else
    logic [4:0] addr_in;
    logic       en_in;
    assign addr_in = lstrap_s2 ? {cell_tx_slave_select, cell_tx_select_bit_zero} : 5'h1f;
    assign en_in   = lstrap_s2 ? ~cell_tx_enable_n : 1'b0;

    logic       sending_r;
    logic [CW-1:0] out_cnt_r;
    logic       sel_r;
    logic       have_cell;
    // a cell leaves only once all its bytes, or 16 if the cell is longer, sit in the queue
    assign have_cell = fill_l >= 5'(CELL_BYTES < 16 ? CELL_BYTES : 16) || sending_r;

    always_ff @(posedge cell_tx_clock) begin
        if (lrst_s2) begin
            wgray_l1 <= '0;
            wgray_l2 <= '0;
        end else begin
            wgray_l1 <= wgray_r;
            wgray_l2 <= wgray_l1;
        end
    end

    logic pop_l;
    assign pop_l = en_in && sel_r && (fill_l != '0) && (sending_r || have_cell);

    always_ff @(posedge cell_tx_clock) begin
        if (lrst_s2) begin
            sel_r                   <= 1'b0;
            sending_r               <= 1'b0;
            out_cnt_r               <= '0;
            rbin_r                  <= '0;
            rgray_r                 <= '0;
            cell_tx_bus             <= cellx_pkg::BUS_RESET;
            cell_tx_bus_oe          <= 1'b0;
            cell_tx_start_marker    <= 1'b0;
            cell_tx_start_marker_oe <= 1'b0;
            cell_tx_available       <= 1'b0;
            cell_tx_available_oe    <= 1'b0;
        end else begin
            if (!en_in) begin
                sel_r <= (addr_in == MY_ADDR) && lstrap_s2;
            end
            cell_tx_available    <= lstrap_s2 && have_cell;
            cell_tx_available_oe <= lstrap_s2 && (addr_in == MY_ADDR);
            cell_tx_bus_oe          <= pop_l;
            cell_tx_start_marker_oe <= pop_l;
            if (pop_l) begin
                // enable sampled now, first byte and marker next cycle
                cell_tx_bus          <= aq_r[rbin_r[3:0]][7:0];
                cell_tx_start_marker <= aq_r[rbin_r[3:0]][8];
                rbin_r               <= rbin_r + 1'b1;
                rgray_r              <= (rbin_r + 1'b1) ^ ((rbin_r + 1'b1) >> 1);
                sending_r            <= (out_cnt_r != CW'(CELL_BYTES - 1));
                out_cnt_r            <= (out_cnt_r == CW'(CELL_BYTES - 1)) ? '0
                                        : out_cnt_r + 1'b1;
            end else begin
                cell_tx_start_marker <= 1'b0;
            end
        end
    end

    sof_follows_a: assert property (@(posedge cell_tx_clock) disable iff (lrst_s2)
        pop_l && aq_r[rbin_r[3:0]][8] |=> cell_tx_start_marker && cell_tx_bus_oe)
        else $error("marker missing after enable");
    strap_tie_a: assert property (@(posedge cell_tx_clock) disable iff (lrst_s2)
        !lstrap_s2 |=> !cell_tx_start_marker && !cell_tx_bus_oe)
        else $error("outputs active while disabled");
    drive_gate_a: assert property (@(posedge cell_tx_clock) disable iff (lrst_s2)
        cell_tx_bus_oe |-> $past(en_in) && $past(sel_r))
        else $error("bus driven unselected");
    avail_off_a: assert property (@(posedge cell_tx_clock) disable iff (lrst_s2)
        !lstrap_s2 |=> !cell_tx_available)
        else $error("available while disabled");
    marker_oe_a: assert property (@(posedge cell_tx_clock) disable iff (lrst_s2)
        cell_tx_start_marker |-> cell_tx_start_marker_oe && cell_tx_bus_oe)
        else $error("marker without bus drive");
    bus_release_a: assert property (@(posedge cell_tx_clock) disable iff (lrst_s2)
        !pop_l |=> !cell_tx_bus_oe && !cell_tx_start_marker_oe)
        else $error("bus driven without enable");
endmodule : cellx_tx_port

// ### test/cellx_master_model.sv
`timescale 1ns/10ps
module cellx_master_model (
    // bench control
    input  wire logic       req,
    input  wire logic [4:0] addr,
    // link
    output logic            cell_tx_clock,
    output logic            cell_tx_enable_n,
    output logic [4:0]      slave_select
);
    // free-running: the slave's status logic needs edges between cells
    initial begin
        cell_tx_clock = 1'b0;
        #7;
        forever #62.5 cell_tx_clock = ~cell_tx_clock;
    end
    initial cell_tx_enable_n = 1'b1;
    initial slave_select = 5'h00;
    always @(posedge cell_tx_clock) begin
        slave_select     <= addr;
        cell_tx_enable_n <= ~req;
    end
endmodule : cellx_master_model

// ### test/test_cellx_tx_port.sv
`timescale 1ns/10ps
module test_cellx_tx_port;
    logic       core_clk;
    logic       reset;
    logic       src_valid;
    logic       src_ready;
    logic [7:0] src_data;
    logic       strap;
    logic       req;
    logic [4:0] addr;
    logic       lclk;
    logic       en_n;
    logic [4:0] sel;
    logic [7:0] bus;
    logic       bus_oe;
    logic       mark;
    logic       mark_oe;
    logic       avail;
    int         n_mismatch;
    int         checks;

    // cell shortened to the queue depth so one whole cell fits
    cellx_tx_port #(.CELL_BYTES(16), .MY_ADDR(5'h00)) u_cellx_tx_port (
        .core_clk(core_clk), .reset(reset), .src_valid(src_valid),
        .src_ready(src_ready), .src_data(src_data), .cell_port_select_strap(strap),
        .cell_tx_clock(lclk), .cell_tx_enable_n(en_n),
        .cell_tx_slave_select(sel[4:1]), .cell_tx_select_bit_zero(sel[0]),
        .cell_tx_bus(bus), .cell_tx_bus_oe(bus_oe), .cell_tx_start_marker(mark),
        .cell_tx_start_marker_oe(mark_oe), .cell_tx_available(avail),
        .cell_tx_available_oe());
    cellx_master_model u_cellx_master_model (.req(req), .addr(addr),
        .cell_tx_clock(lclk), .cell_tx_enable_n(en_n), .slave_select(sel));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic report_and_stop;
        if (n_mismatch == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h", $time, msg, got);
        end
    endtask : check

    task automatic push(input int n);
        int w;
        for (int i = 0; i < n; i++) begin
            src_valid <= 1'b1;
            src_data  <= 8'ha0 + 8'(i);
            w = 0;
            do begin
                @(posedge core_clk);
                w++;
            end while (src_ready !== 1'b1 && w < 2000);
        end
        src_valid <= 1'b0;
    endtask : push

    task automatic t_strap_off;
        @(posedge core_clk);
        strap <= 1'b0;
        req <= 1'b1;
        // let the strap settle through its flops before offering data
        repeat (4) @(posedge core_clk);
        src_valid <= 1'b1;
        repeat (6) @(negedge lclk);
        check({7'h00, src_ready}, 8'h00, "ready while off");
        check({6'h00, bus_oe, mark_oe}, 8'h00, "drives while off");
        check({7'h00, mark}, 8'h00, "marker while off");
        @(posedge core_clk);
        src_valid <= 1'b0;
        req <= 1'b0;
        repeat (4) @(posedge core_clk);
        strap <= 1'b1;
    endtask : t_strap_off

    task automatic t_wrong_addr;
        @(posedge core_clk);
        addr <= 5'h05;
        // address must stand before enable so the slave can deselect
        repeat (3) @(posedge lclk);
        @(posedge core_clk);
        req <= 1'b1;
        repeat (6) begin
            @(negedge lclk);
            check({6'h00, bus_oe, mark_oe}, 8'h00, "other slave drove");
        end
        @(posedge core_clk);
        req <= 1'b0;
        addr <= 5'h00;
        repeat (3) @(negedge lclk);
    endtask : t_wrong_addr

    task automatic t_cell;
        int w;
        w = 0;
        while (avail !== 1'b1 && w < 100) begin
            @(negedge lclk);
            w++;
        end
        check({7'h00, avail}, 8'h01, "available");
        @(posedge core_clk);
        req <= 1'b1;
        w = 0;
        do begin
            @(negedge lclk);
            w++;
        end while (en_n !== 1'b0 && w < 10);
        for (int i = 0; i < 16; i++) begin
            @(negedge lclk);
            check(bus, 8'ha0 + 8'(i), "byte");
            check({6'h00, mark, bus_oe}, {6'h00, i == 0, 1'b1}, "marker");
        end
        @(posedge core_clk);
        req <= 1'b0;
        repeat (4) @(negedge lclk);
        check({7'h00, avail}, 8'h00, "empty");
    endtask : t_cell

    initial begin
        n_mismatch = 0;
        checks = 0;
        reset = 1'b1;
        src_valid = 1'b0;
        src_data = 8'h00;
        strap = 1'b1;
        req = 1'b0;
        addr = 5'h00;
        // long enough for three link edges too
        repeat (20) @(posedge core_clk);
        reset <= 1'b0;
        repeat (40) @(posedge core_clk);
        t_strap_off();
        push(16);
        t_wrong_addr();
        t_cell();
        report_and_stop();
    end

    initial begin
        #500us;
        n_mismatch++;
        report_and_stop();
    end
endmodule : test_cellx_tx_port
